// ===== rtl/ctm_pkg.sv
// Package for the compact timer: register map, field positions, modes.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package ctm_pkg;

  // Register byte addresses
  localparam logic [11:0] CTM_ADDR_CTRL0  = 12'h000;
  localparam logic [11:0] CTM_ADDR_CTRL1  = 12'h004;
  localparam logic [11:0] CTM_ADDR_CNT_LO = 12'h008;
  localparam logic [11:0] CTM_ADDR_CNT_HI = 12'h00C;
  localparam logic [11:0] CTM_ADDR_CMPA_L = 12'h010;
  localparam logic [11:0] CTM_ADDR_CMPA_H = 12'h014;
  localparam logic [11:0] CTM_ADDR_PERIOD = 12'h018;
  localparam logic [11:0] CTM_ADDR_STATUS = 12'h01C;
  localparam logic [11:0] CTM_ADDR_TICK   = 12'h020;

  // Control word 0 fields
  localparam int CTM_C0_PAUSE  = 7;
  localparam int CTM_C0_ENABLE = 3;
  // Control word 1 fields
  localparam int CTM_C1_MODE_HI = 7;
  localparam int CTM_C1_MODE_LO = 6;
  localparam int CTM_C1_ACT_HI  = 5;
  localparam int CTM_C1_ACT_LO  = 4;
  localparam int CTM_C1_INIT    = 3;
  localparam int CTM_C1_INVERT  = 2;
  localparam int CTM_C1_SWAP    = 1;
  localparam int CTM_C1_CLRSEL  = 0;
  // Status fields
  localparam int CTM_ST_MATCH_A = 0;
  localparam int CTM_ST_MATCH_P = 1;

  localparam logic [7:0]  CTM_C0_MASK   = 8'hF8;
  localparam logic [7:0]  CTM_BYTE_RST  = 8'h00;
  localparam logic [15:0] CTM_CNT_RST   = 16'h0000;
  localparam logic [15:0] CTM_CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CTM_CNT_ONE   = 16'h0001;
  localparam logic [7:0]  CTM_LOW_ZERO  = 8'h00;
  localparam logic [7:0]  CTM_TICK_RST  = 8'h00;
  localparam logic [7:0]  CTM_BYTE_ONE  = 8'h01;
  localparam logic [16:0] CTM_FULL_LEN  = 17'h10000;

  typedef enum logic [1:0] {
    CTM_MODE_CMP   = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM   = 2'b10,
    CTM_MODE_TMR   = 2'b11
  } ctm_mode_e;

  // Output action in compare mode
  typedef enum logic [1:0] {
    CTM_ACT_NONE   = 2'b00,
    CTM_ACT_LOW    = 2'b01,
    CTM_ACT_HIGH   = 2'b10,
    CTM_ACT_TOGGLE = 2'b11
  } ctm_act_e;

  // Output action in PWM mode
  typedef enum logic [1:0] {
    CTM_PWM_INACT = 2'b00,
    CTM_PWM_ACT   = 2'b01,
    CTM_PWM_RUN   = 2'b10,
    CTM_PWM_UNDEF = 2'b11
  } ctm_pwm_e;

endpackage : ctm_pkg

// ===== rtl/ctm_tick_gen.sv
// Timer clock tick generator: one-cycle pulse every (divisor+1) pclk cycles.
// Assumes the divisor is steady while the timer runs.
`timescale 1ns/1ns
module ctm_tick_gen #(
  parameter int W = 8
) (
  input  wire logic         pclk,     // APB clock
  input  wire logic         presetn,  // Async reset, active low
  input  wire logic         run,      // Counting allowed
  input  wire logic [W-1:0] div,      // Tick period minus one
  output logic              tick      // Timer clock tick
);
  logic [W-1:0] cnt_q;

  if (W < 1) begin : g_bad_w
    $error("ctm_tick_gen: W must be at least 1");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!run || cnt_q >= div) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign tick = run && (cnt_q >= div);
endmodule : ctm_tick_gen

// ===== rtl/ctm_timer.sv
// Compact 16-bit timer with compare A, period P and one output pin.
// Assumes an APB master on pclk; the pin load is outside this block.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Period byte matches counter bits 15..8; period 256 times value, 65536 if zero.
// - Sixteen-bit compare A in two bytes, compared with all counter bits.
// - Clear-select low: clear on P match, or overflow when period zero.
// - Clear-select low, compare mode: both A and P flags raised.
// - Clear-select high: clear on A match, P flag never raised.
// - Clear-select high, A zero: overflow at FFFF, no A flag.
// - Mode 00 is compare-match output; clears by overflow, A or P.
// - Compare mode changes the pin only on an A match.
// - A match drives high, low, toggles or leaves the pin per action.
// - Enable rising edge loads pin with the initial-level bit.
// - Mode 11 counts and flags like compare mode, pin not driven.
// - Mode 10 is edge-aligned PWM and ignores clear-select.
// - PWM: one compare sets period and clears, other sets duty.
// - Swap zero: P match clears, period 256 times P, duty A.
// - Swap one: A match clears, A is period, 256 times P duty.
// - Duty at or above period gives 100 percent active output.
// - PWM raises A and P flags on their own matches.
// - PWM: initial-level picks active level, action forces, invert flips.
// - PWM counting runs on while output forced inactive or active.
// - PWM action 00 inactive, 01 active, 10 PWM, 11 undefined.
// - Enable rising clears counter; falling stops, keeps value.
// - PWM initial-level high is active high, low active low.
// - Pause freezes counter; resumes from held value.
module ctm_timer
  import ctm_pkg::*;
#(
  parameter int TICK_W = 8
) (
  input  wire logic        pclk,        // APB clock, 100 MHz
  input  wire logic        presetn,     // Async reset, active low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB write
  input  wire logic [11:0] paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  output logic             timer_output_pin, // Timer output level
  output logic             timer_output_oe   // Pin driven by timer
);
  import ctm_pkg::*;

  if (TICK_W < 1 || TICK_W > 8) begin : g_bad_tick_w
    $error("ctm_timer: TICK_W must be 1..8");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [7:0]  compare_a_low_byte_q;
  logic [7:0]  compare_a_high_byte_q;
  logic [7:0]  period_compare_byte_q;
  logic [TICK_W-1:0] tick_div_q;
  logic        match_a_flag_q;
  logic        match_p_flag_q;
  logic [15:0] cnt_q;
  logic        en_prev_q;
  logic        pin_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        oe_q;

  logic        module_enable;
  logic        counter_pause;
  ctm_mode_e   mode;
  logic [1:0]  action;
  logic        initial_level;
  logic        output_invert;
  logic        duty_swap;
  logic        clear_select;
  logic [15:0] compare_value_a;
  logic [7:0]  period_value;

  assign module_enable   = ctrl0_q[CTM_C0_ENABLE];
  assign counter_pause   = ctrl0_q[CTM_C0_PAUSE];
  assign mode            = ctm_mode_e'(ctrl1_q[CTM_C1_MODE_HI:CTM_C1_MODE_LO]);
  assign action          = ctrl1_q[CTM_C1_ACT_HI:CTM_C1_ACT_LO];
  assign initial_level   = ctrl1_q[CTM_C1_INIT];
  assign output_invert   = ctrl1_q[CTM_C1_INVERT];
  assign duty_swap       = ctrl1_q[CTM_C1_SWAP];
  assign clear_select    = ctrl1_q[CTM_C1_CLRSEL];
  assign compare_value_a = {compare_a_high_byte_q, compare_a_low_byte_q};
  assign period_value    = period_compare_byte_q;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic set_en;
  logic clr_a;
  logic clr_p;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    unique case (paddr)
      CTM_ADDR_CTRL0, CTM_ADDR_CTRL1, CTM_ADDR_CNT_LO, CTM_ADDR_CNT_HI,
      CTM_ADDR_CMPA_L, CTM_ADDR_CMPA_H, CTM_ADDR_PERIOD, CTM_ADDR_STATUS,
      CTM_ADDR_TICK: addr_ok = 1'b1;
      default:       addr_ok = 1'b0;
    endcase
  end

  // Flags clear by writing one; a same-cycle match wins
  assign clr_a = wr_en && paddr == CTM_ADDR_STATUS && pwdata[CTM_ST_MATCH_A];
  assign clr_p = wr_en && paddr == CTM_ADDR_STATUS && pwdata[CTM_ST_MATCH_P];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= CTM_BYTE_RST;
      ctrl1_q <= CTM_BYTE_RST;
      tick_div_q <= '0;
    end else if (wr_en) begin
      if (paddr == CTM_ADDR_CTRL0) begin
        ctrl0_q <= pwdata[7:0] & CTM_C0_MASK;
      end
      if (paddr == CTM_ADDR_CTRL1) begin
        ctrl1_q <= pwdata[7:0];
      end
      if (paddr == CTM_ADDR_TICK) begin
        tick_div_q <= pwdata[TICK_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_low_byte_q  <= CTM_BYTE_RST;
      compare_a_high_byte_q <= CTM_BYTE_RST;
      period_compare_byte_q <= CTM_BYTE_RST;
    end else if (wr_en) begin
      if (paddr == CTM_ADDR_CMPA_L) begin
        compare_a_low_byte_q <= pwdata[7:0];
      end
      if (paddr == CTM_ADDR_CMPA_H) begin
        compare_a_high_byte_q <= pwdata[7:0];
      end
      if (paddr == CTM_ADDR_PERIOD) begin
        period_compare_byte_q <= pwdata[7:0];
      end
    end
  end

  // No-wait answer: pready high in the first cycle of the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pready_q  <= 1'b1;
      pslverr_q <= !addr_ok;
      prdata_q  <= '0;
      if (!pwrite) begin
        unique case (paddr)
          CTM_ADDR_CTRL0:  prdata_q[7:0] <= ctrl0_q;
          CTM_ADDR_CTRL1:  prdata_q[7:0] <= ctrl1_q;
          CTM_ADDR_CNT_LO: prdata_q[7:0] <= cnt_q[7:0];
          CTM_ADDR_CNT_HI: prdata_q[7:0] <= cnt_q[15:8];
          CTM_ADDR_CMPA_L: prdata_q[7:0] <= compare_a_low_byte_q;
          CTM_ADDR_CMPA_H: prdata_q[7:0] <= compare_a_high_byte_q;
          CTM_ADDR_PERIOD: prdata_q[7:0] <= period_compare_byte_q;
          CTM_ADDR_STATUS: prdata_q[1:0] <= {match_p_flag_q, match_a_flag_q};
          CTM_ADDR_TICK:   prdata_q[TICK_W-1:0] <= tick_div_q;
          default:         prdata_q <= '0;
        endcase
      end
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter and comparators
  logic tick;
  logic run;
  logic rise_en;
  logic hit_a;
  logic hit_p;
  logic at_max;
  logic a_match;
  logic p_match;
  logic clr_on_a;
  logic clr_on_p;
  logic pwm_mode;

  assign run = module_enable && !counter_pause && mode != CTM_MODE_UNDEF;

  ctm_tick_gen #(
    .W (TICK_W)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .div     (tick_div_q),
    .tick    (tick)
  );

  assign rise_en  = module_enable && !en_prev_q;
  assign pwm_mode = mode == CTM_MODE_PWM;
  assign at_max   = cnt_q == CTM_CNT_MAX;

  // period byte against upper counter bits, at last count of its block
  assign hit_p = period_value == CTM_LOW_ZERO ? at_max
               : (cnt_q[15:8] == period_value - CTM_BYTE_ONE && cnt_q[7:0] == CTM_CNT_MAX[7:0]);
  // full 16-bit compare, hit as the count reaches the value
  assign hit_a = compare_value_a != CTM_CNT_RST &&
                 (cnt_q + CTM_CNT_ONE) == compare_value_a;
  assign a_match = tick && hit_a;
  assign p_match = tick && hit_p;

  // swap picks the comparator that clears
  // clear-select low clears on P or overflow
  assign clr_on_a = pwm_mode ? duty_swap : clear_select;
  assign clr_on_p = !clr_on_a;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= module_enable;
    end
  end

  // enable rising clears; falling keeps value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CTM_CNT_RST;
    end else if (rise_en) begin
      cnt_q <= CTM_CNT_RST;
    end else if (tick) begin
      if ((clr_on_a && hit_a) || (clr_on_p && hit_p) || at_max) begin
        cnt_q <= CTM_CNT_RST;
      end else begin
        cnt_q <= cnt_q + CTM_CNT_ONE;
      end
    end
  end

  // no P flag when clear-select high outside PWM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
    end else begin
      match_a_flag_q <= a_match || (match_a_flag_q && !clr_a);
      match_p_flag_q <= (p_match && (pwm_mode || !clear_select)) ||
                        (match_p_flag_q && !clr_p);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pin
  logic [16:0] duty_len;
  logic [16:0] per_len;
  logic [16:0] pos;
  logic [16:0] p_len;
  logic        pwm_active;
  logic        pwm_level;

  // duty not below period holds active level
  assign p_len    = period_value == CTM_LOW_ZERO ? CTM_FULL_LEN
                  : {1'b0, period_value, CTM_LOW_ZERO};
  assign per_len  = duty_swap ? {1'b0, compare_value_a} : p_len;
  assign duty_len = duty_swap ? p_len : {1'b0, compare_value_a};
  assign pos      = {1'b0, cnt_q};
  assign pwm_active = (duty_len >= per_len) || (pos < duty_len);

  always_comb begin
    unique case (ctm_pwm_e'(action))
      CTM_PWM_INACT: pwm_level = !initial_level;
      CTM_PWM_ACT:   pwm_level = initial_level;
      CTM_PWM_RUN:   pwm_level = pwm_active ? initial_level : !initial_level;
      CTM_PWM_UNDEF: pwm_level = !initial_level;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else if (rise_en) begin
      pin_q <= initial_level;
    end else if (mode == CTM_MODE_PWM) begin
      pin_q <= pwm_level;
    end else if (mode == CTM_MODE_CMP && a_match) begin
      // only A match moves the pin
      unique case (ctm_act_e'(action))
        CTM_ACT_NONE:   pin_q <= pin_q;
        CTM_ACT_LOW:    pin_q <= 1'b0;
        CTM_ACT_HIGH:   pin_q <= 1'b1;
        CTM_ACT_TOGGLE: pin_q <= !pin_q;
      endcase
    end
  end

  // compare mode drives pin; timer mode releases it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= mode == CTM_MODE_CMP || mode == CTM_MODE_PWM;
    end
  end

  logic pin_out_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
    end else begin
      pin_out_q <= pin_q ^ output_invert;
    end
  end

  assign timer_output_pin = pin_out_q;
  assign timer_output_oe  = oe_q;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
endmodule : ctm_timer

// ===== verif/ctm_timer_chk.sv
// Checker for the compact timer: APB handshake, byte registers, pin enable.
// Assumes it is bound to ctm_timer and sees only its ports.
`timescale 1ns/1ns
module ctm_timer_chk
  import ctm_pkg::*;
#(
  parameter int TICK_W = 8
) (
  input wire logic        pclk,             // APB clock
  input wire logic        presetn,          // Async reset, active low
  input wire logic        psel,             // APB select
  input wire logic        penable,          // APB access phase
  input wire logic        pwrite,           // APB write
  input wire logic [11:0] paddr,            // APB byte address
  input wire logic [31:0] pwdata,           // APB write data
  input wire logic [31:0] prdata,           // APB read data
  input wire logic        pready,           // APB ready
  input wire logic        pslverr,          // APB error
  input wire logic        timer_output_pin, // Timer output level
  input wire logic        timer_output_oe   // Pin driven by timer
);
  logic [7:0] byte_q [3];
  logic       mode_lo_q;
  logic       xfer;
  logic       is_byte;
  assign xfer    = psel && penable && pready;
  assign is_byte = paddr >= CTM_ADDR_CMPA_L && paddr <= CTM_ADDR_PERIOD && paddr[1:0] == 2'b00;
  // Shadow copies, so read data can be tied to what was written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_q    <= '{default: 8'h00};
      mode_lo_q <= 1'b0;
    end else if (xfer && pwrite) begin
      if (is_byte) byte_q[paddr[3:2]] <= pwdata[7:0];
      if (paddr == CTM_ADDR_CTRL1) mode_lo_q <= pwdata[CTM_C1_MODE_LO];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_ready_no_wait: assert property (psel && !penable |=> pready)
    else $error("access phase not answered at once");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmapped: assert property (xfer && paddr > CTM_ADDR_TICK |-> pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (xfer && paddr <= CTM_ADDR_TICK && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("mapped address refused");
  a_unmapped_zero: assert property (xfer && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_byte_readback: assert property (xfer && !pwrite && is_byte
    |-> prdata == {24'h0, byte_q[paddr[3:2]]}) else $error("byte register read wrong");
  a_oe_follows_mode: assert property (xfer && pwrite && paddr == CTM_ADDR_CTRL1
    |-> ##2 (timer_output_oe == !mode_lo_q)) else $error("pin enable does not follow mode");
endmodule : ctm_timer_chk

bind ctm_timer ctm_timer_chk #(.TICK_W(TICK_W)) ctm_timer_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe));

// ===== verif/ctm_load_model.sv
// Load on the timer output pin: counts the cycles it sees a high level.
// Assumes a pull-down holds the line low when the timer does not drive it.
`timescale 1ns/1ns
module ctm_load_model (
  input  wire logic        pclk,    // Sampling clock
  input  wire logic        clr,     // Restart the count
  input  wire logic        pin,     // Timer output level
  input  wire logic        oe,      // Timer drives the pin
  output logic      [31:0] high_cnt // Cycles seen high
);
  logic line;
  // Pull-down wins while undriven
  assign line = oe & pin;
  always_ff @(posedge pclk) begin
    if (clr) begin
      high_cnt <= 32'h0;
    end else begin
      high_cnt <= high_cnt + {31'h0, line};
    end
  end
endmodule : ctm_load_model

// ===== verif/ctm_timer_test.sv
// Testbench for the compact timer: registers, modes 00, 10 and 11, pause and enable.
// Assumes tick divisor at reset, one timer tick per pclk, until the last test.
`timescale 1ns/1ns
module ctm_timer_test;
  import ctm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ld_clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, high_cnt, r0, r1;
  logic        pready, pslverr, pin, oe, err_seen;
  int          miscompares, n_compared;

  ctm_timer ctm_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_output_pin(pin), .timer_output_oe(oe));
  ctm_load_model ctm_load_model_inst (.pclk(pclk), .clr(ld_clr), .pin(pin), .oe(oe),
    .high_cnt(high_cnt));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a missing answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] junk;
    apb(1'b1, a, d, junk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask : rd

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Configure while stopped, start, then count high cycles over whole periods
  task automatic run_case(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
                          input int win, input logic [31:0] exp_hi, input logic [1:0] exp_fl);
    logic [31:0] r;
    wr(CTM_ADDR_CTRL0, 32'h0);
    wr(CTM_ADDR_STATUS, 32'h3);
    wr(CTM_ADDR_CMPA_L, {24'h0, a[7:0]});
    wr(CTM_ADDR_CMPA_H, {24'h0, a[15:8]});
    wr(CTM_ADDR_PERIOD, {24'h0, p});
    wr(CTM_ADDR_CTRL1, {24'h0, c1});
    wr(CTM_ADDR_CTRL0, 32'h8);
    repeat (4) @(posedge pclk);
    if (c1[7:6] == 2'b00) chk("start level", {31'h0, c1[3] ^ c1[2]}, {31'h0, pin});
    chk("pin enable", {31'h0, ~c1[6]}, {31'h0, oe});
    repeat (300) @(posedge pclk);
    ld_clr <= 1'b1;
    @(posedge pclk);
    ld_clr <= 1'b0;
    repeat (win) @(posedge pclk);
    #1;
    chk("high cycles", exp_hi, high_cnt);
    rd(CTM_ADDR_STATUS, r);
    chk("match flags", {30'h0, exp_fl}, r & 32'h3);
  endtask : run_case

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; ld_clr = 1'b0;
    miscompares = 0; n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(CTM_ADDR_CMPA_L + 12'(4 * i), r0);
      chk("reset value", 32'h0, r0);
      wr(CTM_ADDR_CMPA_L + 12'(4 * i), 32'hA5 + 32'(i));
      rd(CTM_ADDR_CMPA_L + 12'(4 * i), r0);
      chk("readback", 32'hA5 + 32'(i), r0);
    end
    rd(12'h024, r0);
    chk("unmapped data", 32'h0, r0);
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    $display("test registers done");
    run_case(8'h30, 16'h0040, 8'h01, 512, 32'h100, 2'b11);
    run_case(8'h31, 16'h0040, 8'h01, 512, 32'h100, 2'b01);
    run_case(8'h18, 16'h0040, 8'h01, 512, 32'h0, 2'b11);
    run_case(8'h20, 16'h0040, 8'h01, 512, 32'h200, 2'b11);
    run_case(8'h08, 16'h0040, 8'h01, 512, 32'h200, 2'b11);
    run_case(8'hF0, 16'h0040, 8'h01, 512, 32'h0, 2'b11);
    run_case(8'hA8, 16'h0040, 8'h01, 512, 32'h80, 2'b11);
    run_case(8'hA9, 16'h0040, 8'h01, 512, 32'h80, 2'b11);
    run_case(8'hAC, 16'h0040, 8'h01, 512, 32'h180, 2'b11);
    run_case(8'hA0, 16'h0040, 8'h01, 512, 32'h180, 2'b11);
    run_case(8'h88, 16'h0040, 8'h01, 512, 32'h0, 2'b11);
    run_case(8'h98, 16'h0040, 8'h01, 512, 32'h200, 2'b11);
    run_case(8'hB8, 16'h0040, 8'h01, 512, 32'h0, 2'b11);
    run_case(8'hA8, 16'h0200, 8'h01, 512, 32'h200, 2'b10);
    run_case(8'hAA, 16'h0300, 8'h01, 1536, 32'h200, 2'b11);
    $display("test modes done");
    run_case(8'hF1, 16'h0000, 8'h01, 512, 32'h0, 2'b00);
    run_case(8'hC0, 16'h0300, 8'h00, 16, 32'h0, 2'b00);
    wr(CTM_ADDR_CTRL0, 32'h88);
    rd(CTM_ADDR_CNT_LO, r0);
    rd(CTM_ADDR_CNT_HI, r1);
    chk("count past 255", 32'h1, r1);
    repeat (50) @(posedge pclk);
    rd(CTM_ADDR_CNT_LO, r1);
    chk("paused count", r0, r1);
    wr(CTM_ADDR_CTRL0, 32'h8);
    repeat (20) @(posedge pclk);
    rd(CTM_ADDR_CNT_LO, r1);
    chk("count resumed", (r0 + 32'h15) & 32'hFF, r1);
    wr(CTM_ADDR_CTRL0, 32'h0);
    rd(CTM_ADDR_CNT_LO, r0);
    repeat (20) @(posedge pclk);
    rd(CTM_ADDR_CNT_LO, r1);
    chk("stopped count", r0, r1);
    wr(CTM_ADDR_CTRL0, 32'h8);
    rd(CTM_ADDR_CNT_HI, r1);
    chk("restart clears", 32'h0, r1);
    wr(CTM_ADDR_TICK, 32'h1);
    rd(CTM_ADDR_TICK, r1);
    chk("tick divisor", 32'h1, r1);
    wr(CTM_ADDR_CTRL0, 32'h0);
    wr(CTM_ADDR_CTRL0, 32'h8);
    // One tick every second pclk from the restart
    repeat (20) @(posedge pclk);
    rd(CTM_ADDR_CNT_LO, r1);
    chk("slow tick count", 32'h0A, r1);
    $display("test pause done");
    conclude();
  end

  // Whole run is near 15000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    conclude();
  end
endmodule : ctm_timer_test
